// ==== smrr_client_model.sv ====
// Reply sink standing for the network client.
// Assumes the server's valid/ready reply stream on the same clock.
`timescale 1ns/1ps

module smrr_client_model (
   // Clock and reset
   input wire logic mclk_in,
   input wire logic arst_n_in,
   // Pacing
   input wire logic slow_in,
   // Reply stream from the server
   input wire logic tx_valid_in,
   input wire logic [7:0] tx_data_in,
   input wire logic tx_last_in,
   output logic ready_out,
   // Accepted bytes
   output logic got_out,
   output logic [7:0] got_data_out,
   output logic got_last_out
);
   // --------------------------------------
   // Slow client opens every other cycle
   // --------------------------------------
   logic tog_reg;
   always_ff @(posedge mclk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         tog_reg <= 1'b0;
      end else begin
         tog_reg <= !tog_reg;
      end
   end
   assign ready_out = !slow_in || tog_reg;
   assign got_out = tx_valid_in && ready_out;
   assign got_data_out = tx_data_in;
   assign got_last_out = tx_last_in;
endmodule

// ==== smrr_pkg.sv ====
// Constants and types for the register-read command interpreter.
// Assumes one clock domain; frames arrive as whole byte streams.
package smrr_pkg;

   // ------------------------------------------------------------
   // Function and exception codes
   // ------------------------------------------------------------
   localparam logic [7:0] FC_READ_DISCRETE = 8'h02;
   localparam logic [7:0] FC_READ_HOLDING = 8'h03;
   localparam logic [7:0] FC_READ_INPUT = 8'h04;
   localparam logic [7:0] FC_ERROR_FLAG = 8'h80;
   localparam logic [7:0] EXC_BAD_FUNCTION = 8'h01;
   localparam logic [7:0] EXC_BAD_ADDRESS = 8'h02;
   localparam logic [7:0] EXC_BAD_QUANTITY = 8'h03;

   // ------------------------------------------------------------
   // Framing
   // ------------------------------------------------------------
   localparam logic [3:0] REQ_LAST_INDEX = 4'hb;
   localparam logic [8:0] HDR_BYTES = 9'h009;
   localparam logic [7:0] LEN_BASE = 8'h03;
   localparam logic [15:0] PROTOCOL_ZERO = 16'h0000;
   localparam logic [15:0] REG_QTY_MAX = 16'h007d;
   localparam logic [15:0] BIT_QTY_MAX = 16'h0040;
   localparam logic [16:0] BIT_ADDR_END = 17'h00040;

   // ------------------------------------------------------------
   // Register word addresses
   // ------------------------------------------------------------
   localparam logic [15:0] ADDR_MOTOR_MODEL_CODE = 16'h2000;
   localparam logic [15:0] ADDR_ENCODER_KIND = 16'h2001;
   localparam logic [15:0] ADDR_COUNTS_LO = 16'h2002;
   localparam logic [15:0] ADDR_COUNTS_HI = 16'h2003;
   localparam logic [16:0] ADDR_PARAM_END = 17'h02004;
   localparam logic [15:0] ADDR_DRIVE_OUTPUT_STATUS = 16'h2121;
   localparam logic [15:0] ADDR_PRESENT_SPEED = 16'h2600;

   // Contact positions inside the output status word
   localparam int BRAKE_BIT = 0;
   localparam int ZERO_SPEED_BIT = 3;
   localparam int CAUTION_BIT = 8;

   // ------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------
   localparam logic [95:0] SHIFT_RESET = 96'h0;
   localparam logic [8:0] INDEX_RESET = 9'h000;
   localparam logic [7:0] BYTE_RESET = 8'h00;

   typedef struct packed {
      logic [15:0] tid;
      logic [7:0] uid;
      logic [7:0] fc;
      logic [15:0] start;
      logic [15:0] qty;
   } smrr_req_t;

   localparam smrr_req_t REQ_RESET = '0;

endpackage

// ==== smrr_server.sv ====
// Server end of the register-read function codes over a byte stream.
// Assumes the transport hands in one request frame per rx_last_in and
// takes reply bytes under tx_ready_in; drive values are on mclk_in.
//
// Notes on behaviour
// - A holding read of 1 to 4 words inside 0x2000-0x2003, or one word at 0x2600, answers byte count 2N, then N words.
// - An input-register read of one word at 0x2121 answers 2N, then N words; all others are refused.
// - A refused read answers the function code with bit 7 set, then a code.
// - Status word bits: brake 0, zero speed 3, caution 8, one contact each.
// - The present speed is one word at 0x2600 read by a holding read.
// - A holding read at 0x2000 returns motor code, kind, counts low, high.
// - The encoder kind word sits at 0x2001 right after the motor code.
// - A one-word input read at 0x2121 returns the status word, count 2.
// - A discrete read packs one bit per contact, byte count rounded up.
`timescale 1ns/1ps

module smrr_server (
   // Clock and reset
   input wire logic mclk_in,
   input wire logic arst_n_in,
   // Request byte stream
   input wire logic rx_valid_in,
   input wire logic [7:0] rx_data_in,
   input wire logic rx_last_in,
   output logic rx_ready_out,
   // Reply byte stream
   output logic tx_valid_out,
   output logic [7:0] tx_data_out,
   output logic tx_last_out,
   input wire logic tx_ready_in,
   // Drive values
   input wire logic forward_travel_limit_in,
   input wire logic [15:1] input_contacts_in,
   input wire logic [15:0] output_contacts_in,
   input wire logic [15:0] present_speed_in,
   input wire logic [15:0] motor_model_code_in,
   input wire logic [15:0] encoder_kind_in,
   input wire logic [31:0] encoder_counts_per_turn_in
);

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   typedef enum logic {ST_RECV, ST_SEND} smrr_state_t;

   smrr_state_t state_reg, state_next;
   logic [3:0] rxcnt_reg, rxcnt_next;
   logic [95:0] shift_reg, shift_next;
   smrr_pkg::smrr_req_t req_reg, req_next;
   logic [7:0] exc_reg, exc_next;
   logic [7:0] bc_reg, bc_next;
   logic [8:0] idx_reg, idx_next;
   logic rdy_reg, rdy_next;
   logic txv_reg, txv_next;
   logic [7:0] txd_reg, txd_next;
   logic txl_reg, txl_next;

   logic [95:0] frame;
   smrr_pkg::smrr_req_t req_new;
   logic [15:0] protocol;
   logic [16:0] addr_end;
   logic [7:0] exc_new;
   logic [7:0] bc_new;
   logic [63:0] contacts;
   logic [15:0] status_word;
   logic [8:0] total;
   logic [8:0] data_k;
   logic [7:0] out_byte;

   // Unsupported contact ranges read as zero
   assign status_word = output_contacts_in;
   assign contacts = {16'h0000, status_word, 16'h0000,
                      input_contacts_in, forward_travel_limit_in};

   // ------------------------------------------------------------
   // Request decode
   // ------------------------------------------------------------
   assign frame = {shift_reg[87:0], rx_data_in};
   assign protocol = frame[79:64];
   assign req_new.tid = frame[95:80];
   assign req_new.uid = frame[47:40];
   assign req_new.fc = frame[39:32];
   assign req_new.start = frame[31:16];
   assign req_new.qty = frame[15:0];
   assign addr_end = {1'b0, req_new.start} + {1'b0, req_new.qty};

   always_comb begin
      exc_new = smrr_pkg::BYTE_RESET;
      bc_new = smrr_pkg::BYTE_RESET;
      unique case (req_new.fc)
         smrr_pkg::FC_READ_DISCRETE: begin
            bc_new = 8'(req_new.qty[6:0] + 7'h07) >> 3;
            if (req_new.qty == 16'h0000 ||
                req_new.qty > smrr_pkg::BIT_QTY_MAX) begin
               exc_new = smrr_pkg::EXC_BAD_QUANTITY;
            end else if (addr_end > smrr_pkg::BIT_ADDR_END) begin
               exc_new = smrr_pkg::EXC_BAD_ADDRESS;
            end
         end
         smrr_pkg::FC_READ_HOLDING: begin
            bc_new = {req_new.qty[6:0], 1'b0};
            if (req_new.qty == 16'h0000 ||
                req_new.qty > smrr_pkg::REG_QTY_MAX) begin
               exc_new = smrr_pkg::EXC_BAD_QUANTITY;
            end else if (!((req_new.start >= smrr_pkg::ADDR_MOTOR_MODEL_CODE
                            && addr_end <= smrr_pkg::ADDR_PARAM_END) ||
                           (req_new.start == smrr_pkg::ADDR_PRESENT_SPEED
                            && req_new.qty == 16'h0001))) begin
               exc_new = smrr_pkg::EXC_BAD_ADDRESS;
            end
         end
         smrr_pkg::FC_READ_INPUT: begin
            bc_new = {req_new.qty[6:0], 1'b0};
            if (req_new.qty == 16'h0000 ||
                req_new.qty > smrr_pkg::REG_QTY_MAX) begin
               exc_new = smrr_pkg::EXC_BAD_QUANTITY;
            end else if (!(req_new.start ==
                           smrr_pkg::ADDR_DRIVE_OUTPUT_STATUS &&
                           req_new.qty == 16'h0001)) begin
               exc_new = smrr_pkg::EXC_BAD_ADDRESS;
            end
         end
         default: begin
            exc_new = smrr_pkg::EXC_BAD_FUNCTION;
         end
      endcase
   end

   // ------------------------------------------------------------
   // Reply byte selection
   // ------------------------------------------------------------
   function automatic logic [15:0] word_at(input logic [7:0] fc,
                                           input logic [15:0] addr);
      logic [15:0] w;
      w = 16'h0000;
      if (fc == smrr_pkg::FC_READ_INPUT) begin
         if (addr == smrr_pkg::ADDR_DRIVE_OUTPUT_STATUS) begin
            w = status_word;
         end
      end else begin
         unique case (addr)
            smrr_pkg::ADDR_MOTOR_MODEL_CODE: w = motor_model_code_in;
            smrr_pkg::ADDR_ENCODER_KIND: w = encoder_kind_in;
            smrr_pkg::ADDR_COUNTS_LO:
               w = encoder_counts_per_turn_in[15:0];
            smrr_pkg::ADDR_COUNTS_HI:
               w = encoder_counts_per_turn_in[31:16];
            smrr_pkg::ADDR_PRESENT_SPEED: w = present_speed_in;
            default: w = 16'h0000;
         endcase
      end
      return w;
   endfunction

   function automatic logic [7:0] bits_at(input logic [15:0] start,
                                          input logic [15:0] qty,
                                          input logic [7:0] j);
      logic [7:0] b;
      logic [15:0] n;
      logic [15:0] pos;
      b = 8'h00;
      for (int i = 0; i < 8; i++) begin
         n = {5'h00, j, 3'(i)};
         pos = start + n;
         // Contacts beyond the requested count pad with zero
         if (n < qty) begin
            b[i] = contacts[pos[5:0]];
         end
      end
      return b;
   endfunction

   assign total = (exc_reg != smrr_pkg::BYTE_RESET) ? smrr_pkg::HDR_BYTES
                  : smrr_pkg::HDR_BYTES + {1'b0, bc_reg};
   assign data_k = idx_reg - smrr_pkg::HDR_BYTES;

   always_comb begin
      logic [15:0] w;
      logic [7:0] len;
      w = word_at(req_reg.fc, req_reg.start + {8'h00, data_k[8:1]});
      len = (exc_reg != smrr_pkg::BYTE_RESET) ? smrr_pkg::LEN_BASE
            : smrr_pkg::LEN_BASE + bc_reg;
      unique case (idx_reg)
         9'h000: out_byte = req_reg.tid[15:8];
         9'h001: out_byte = req_reg.tid[7:0];
         9'h002: out_byte = smrr_pkg::PROTOCOL_ZERO[15:8];
         9'h003: out_byte = smrr_pkg::PROTOCOL_ZERO[7:0];
         9'h004: out_byte = 8'h00;
         9'h005: out_byte = len;
         9'h006: out_byte = req_reg.uid;
         9'h007: out_byte = (exc_reg != smrr_pkg::BYTE_RESET) ?
                            (req_reg.fc | smrr_pkg::FC_ERROR_FLAG)
                            : req_reg.fc;
         9'h008: out_byte = (exc_reg != smrr_pkg::BYTE_RESET) ?
                            exc_reg : bc_reg;
         default: begin
            if (req_reg.fc == smrr_pkg::FC_READ_DISCRETE) begin
               out_byte = bits_at(req_reg.start, req_reg.qty, data_k[7:0]);
            end else begin
               out_byte = data_k[0] ? w[7:0] : w[15:8];
            end
         end
      endcase
   end

   // ------------------------------------------------------------
   // Sequencing
   // ------------------------------------------------------------
   always_comb begin
      state_next = state_reg;
      rxcnt_next = rxcnt_reg;
      shift_next = shift_reg;
      req_next = req_reg;
      exc_next = exc_reg;
      bc_next = bc_reg;
      idx_next = idx_reg;
      rdy_next = rdy_reg;
      txv_next = txv_reg;
      txd_next = txd_reg;
      txl_next = txl_reg;
      unique case (state_reg)
         ST_RECV: begin
            if (rx_valid_in && rdy_reg) begin
               shift_next = frame;
               if (rxcnt_reg != 4'hf) begin
                  rxcnt_next = rxcnt_reg + 4'h1;
               end
               if (rx_last_in) begin
                  rxcnt_next = 4'h0;
                  // Wrong length or nonzero protocol: dropped silently
                  if (rxcnt_reg == smrr_pkg::REQ_LAST_INDEX &&
                      protocol == smrr_pkg::PROTOCOL_ZERO) begin
                     req_next = req_new;
                     exc_next = exc_new;
                     bc_next = bc_new;
                     idx_next = smrr_pkg::INDEX_RESET;
                     rdy_next = 1'b0;
                     state_next = ST_SEND;
                  end
               end
            end
         end
         ST_SEND: begin
            if (txv_reg && tx_ready_in && txl_reg) begin
               txv_next = 1'b0;
               txl_next = 1'b0;
               rdy_next = 1'b1;
               state_next = ST_RECV;
            end else if ((!txv_reg || tx_ready_in) && idx_reg < total) begin
               txv_next = 1'b1;
               txd_next = out_byte;
               txl_next = (idx_reg == total - 9'h001);
               idx_next = idx_reg + 9'h001;
            end
         end
      endcase
   end

   always_ff @(posedge mclk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         state_reg <= ST_RECV;
         rxcnt_reg <= 4'h0;
         shift_reg <= smrr_pkg::SHIFT_RESET;
         req_reg <= smrr_pkg::REQ_RESET;
         exc_reg <= smrr_pkg::BYTE_RESET;
         bc_reg <= smrr_pkg::BYTE_RESET;
         idx_reg <= smrr_pkg::INDEX_RESET;
         rdy_reg <= 1'b1;
         txv_reg <= 1'b0;
         txd_reg <= smrr_pkg::BYTE_RESET;
         txl_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         rxcnt_reg <= rxcnt_next;
         shift_reg <= shift_next;
         req_reg <= req_next;
         exc_reg <= exc_next;
         bc_reg <= bc_next;
         idx_reg <= idx_next;
         rdy_reg <= rdy_next;
         txv_reg <= txv_next;
         txd_reg <= txd_next;
         txl_reg <= txl_next;
      end
   end

   assign rx_ready_out = rdy_reg;
   assign tx_valid_out = txv_reg;
   assign tx_data_out = txd_reg;
   assign tx_last_out = txl_reg;

endmodule

// ==== smrr_server_props.sv ====
// Reply-stream checks for the register-read server.
// Sees only the server's ports; bound from the testbench top file.
`timescale 1ns/1ps

module smrr_server_props (
   // Clock and reset
   input wire logic mclk_in,
   input wire logic arst_n_in,
   // Streams and drive values
   input wire logic rx_ready_out,
   input wire logic tx_valid_out,
   input wire logic [7:0] tx_data_out,
   input wire logic tx_last_out,
   input wire logic tx_ready_in,
   input wire logic [15:0] output_contacts_in
);
   // ---------------------------------------------
   // Reply byte position, length and function code
   // ---------------------------------------------
   logic [7:0] idx;
   logic [7:0] fc;
   logic [7:0] len;
   logic acc;
   assign acc = tx_valid_out && tx_ready_in;
   always_ff @(posedge mclk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         idx <= 8'h00;
         fc <= 8'h00;
         len <= 8'h00;
      end else if (acc) begin
         idx <= tx_last_out ? 8'h00 : idx + 8'h01;
         if (idx == 8'h05) begin
            len <= tx_data_out;
         end
         if (idx == 8'h07) begin
            fc <= tx_data_out;
         end
      end
   end
   // ---------------------------------------------
   // Properties
   // ---------------------------------------------
   default clocking cb @(posedge mclk_in);
   endclocking
   default disable iff (!arst_n_in);
   sequence stall_s;
      tx_valid_out && !tx_ready_in;
   endsequence
   sequence end_s;
      acc && tx_last_out;
   endsequence
   a_byte_held: assert property (stall_s |=> tx_valid_out &&
      $stable(tx_data_out) && $stable(tx_last_out))
      else $error("reply byte changed before it was taken");
   a_busy_no_rx: assert property (tx_valid_out |-> !rx_ready_out)
      else $error("request side open while replying");
   a_free_after: assert property (end_s |=>
      rx_ready_out && !tx_valid_out)
      else $error("server not idle after reply end");
   a_header_zero: assert property (tx_valid_out &&
      idx inside {8'h02, 8'h03, 8'h04} |-> tx_data_out == 8'h00)
      else $error("protocol or length high byte not zero");
   a_length_field: assert property (tx_valid_out && tx_last_out |->
      idx == len + 8'h05)
      else $error("length field does not match reply size");
   a_exc_reply: assert property (tx_valid_out && idx == 8'h08 && fc[7]
      |-> tx_last_out && len == 8'h03 && tx_data_out inside {[8'h01:8'h06]})
      else $error("bad exception reply");
   a_byte_count: assert property (tx_valid_out && idx == 8'h08 && !fc[7]
      |-> tx_data_out == len - 8'h03)
      else $error("byte count does not match length");
   a_status_word: assert property (tx_valid_out && fc == 8'h04 &&
      idx inside {8'h09, 8'h0a} |-> tx_data_out == (idx == 8'h09 ?
      output_contacts_in[15:8] : output_contacts_in[7:0]))
      else $error("output status word wrong");
endmodule

// ==== tb_servo_modbus_register_read.sv ====
// Self-checking bench for the register-read server.
// Drives request frames, the client model sinks the reply bytes.
`timescale 1ns/1ps

module tb_servo_modbus_register_read;
   typedef logic [7:0] smrr_bytes_t[$];
   logic mclk_in, arst_n_in, rx_valid_in, rx_last_in, rx_ready_out;
   logic tx_valid_out, tx_last_out, tx_ready_in, ftl, slow, got;
   logic got_last;
   int ends = 0;
   logic [7:0] rx_data_in, tx_data_out, got_data, uid;
   logic [15:1] in_c;
   logic [15:0] out_c, speed, motor, kind, tid;
   logic [31:0] counts;
   logic [7:0] rep[$];
   int mismatches, compares;
   logic [7:0] ef[7] = '{8'h05, 8'h03, 8'h03, 8'h04, 8'h03, 8'h02, 8'h02};
   logic [15:0] es[7] = '{16'h0000, 16'h2600, 16'h2600, 16'h2122,
      16'h2600, 16'h003e, 16'h0000};
   logic [15:0] eq[7] = '{16'h0001, 16'h0000, 16'h007e, 16'h0001,
      16'h0002, 16'h0003, 16'h0041};
   logic [7:0] ec[7] = '{8'h01, 8'h03, 8'h03, 8'h02, 8'h02, 8'h02, 8'h03};

   smrr_server dut (.mclk_in(mclk_in), .arst_n_in(arst_n_in),
      .rx_valid_in(rx_valid_in), .rx_data_in(rx_data_in),
      .rx_last_in(rx_last_in), .rx_ready_out(rx_ready_out),
      .tx_valid_out(tx_valid_out), .tx_data_out(tx_data_out),
      .tx_last_out(tx_last_out), .tx_ready_in(tx_ready_in),
      .forward_travel_limit_in(ftl), .input_contacts_in(in_c),
      .output_contacts_in(out_c), .present_speed_in(speed),
      .motor_model_code_in(motor), .encoder_kind_in(kind),
      .encoder_counts_per_turn_in(counts));
   smrr_client_model client (.mclk_in(mclk_in), .arst_n_in(arst_n_in),
      .slow_in(slow), .tx_valid_in(tx_valid_out), .tx_data_in(tx_data_out),
      .tx_last_in(tx_last_out), .ready_out(tx_ready_in), .got_out(got),
      .got_data_out(got_data), .got_last_out(got_last));

   // ------------------------------------
   // Clock, reply capture and tasks
   // ------------------------------------
   initial begin
      mclk_in = 1'b0;
      forever #20 mclk_in = ~mclk_in;
   end
   always @(posedge mclk_in) begin
      if (got) begin
         rep.push_back(got_data);
         if (got_last) begin
            ends++;
         end
      end
   end
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value at %0t: seen %h exp %h", $time, seen, exp);
      end
   endtask
   task send(input logic [7:0] fc, input logic [15:0] st, qty, prt);
      logic [95:0] f;
      f = {tid, prt, 16'h0006, uid, fc, st, qty};
      for (int k = 0; k < 12; k++) begin
         rx_valid_in <= 1'b1;
         rx_data_in <= f[95 - 8 * k -: 8];
         rx_last_in <= (k == 11);
         @(posedge mclk_in);
      end
      rx_valid_in <= 1'b0;
      rx_last_in <= 1'b0;
   endtask
   task run(input logic [7:0] fc, fcx, input logic [15:0] st, qty,
            input smrr_bytes_t pl);
      logic [7:0] e[$];
      int n;
      int e0;
      tid = tid + 16'h0001;
      uid = uid + 8'h01;
      e = {tid[15:8], tid[7:0], 8'h00, 8'h00, 8'h00, 8'(pl.size() + 2)};
      e = {e, uid, fcx, pl};
      rep.delete();
      e0 = ends;
      send(fc, st, qty, 16'h0000);
      n = 0;
      while (ends == e0 && n < 400) begin
         @(posedge mclk_in);
         n++;
      end
      chk(ends - e0, 1);
      chk(rep.size(), e.size());
      foreach (e[i]) chk(rep[i], e[i]);
      @(posedge mclk_in);
   endtask
   task print_verdict;
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // ------------------------------------
   // Tests
   // ------------------------------------
   initial begin
      repeat (5000) @(posedge mclk_in);
      mismatches++;
      print_verdict;
   end
   initial begin
      mismatches = 0;
      compares = 0;
      arst_n_in = 1'b0;
      rx_valid_in = 1'b0;
      rx_last_in = 1'b0;
      rx_data_in = 8'h00;
      ftl = 1'b0;
      slow = 1'b0;
      tid = 16'ha000;
      uid = 8'h10;
      in_c = 15'h0081;
      out_c = 16'h0000;
      out_c[smrr_pkg::BRAKE_BIT] = 1'b1;
      out_c[smrr_pkg::ZERO_SPEED_BIT] = 1'b1;
      out_c[smrr_pkg::CAUTION_BIT] = 1'b1;
      speed = 16'h1234;
      motor = 16'h0a5c; // Arbitrary model code
      kind = 16'h0004;
      counts = 32'h0008_1357;
      repeat (3) @(posedge mclk_in);
      arst_n_in <= 1'b1;
      @(posedge mclk_in);
      run(8'h03, 8'h03, 16'h2600, 16'h0001, {8'h02, 8'h12, 8'h34});
      run(8'h03, 8'h03, 16'h2000, 16'h0004, {8'h08, 8'h0a, 8'h5c, 8'h00,
         8'h04, 8'h13, 8'h57, 8'h00, 8'h08});
      chk({rep[15], rep[16], rep[13], rep[14]}, counts);
      run(8'h03, 8'h03, 16'h2001, 16'h0001, {8'h02, 8'h00, 8'h04});
      slow <= 1'b1;
      run(8'h04, 8'h04, 16'h2121, 16'h0001, {8'h02, 8'h01, 8'h09});
      run(8'h02, 8'h02, 16'h0000, 16'h0001, {8'h01, 8'h00});
      run(8'h02, 8'h02, 16'h0000, 16'h0009, {8'h02, 8'h02, 8'h01});
      slow <= 1'b0;
      foreach (ef[i]) run(ef[i], ef[i] | 8'h80, es[i], eq[i], {ec[i]});
      rep.delete();
      send(8'h03, 16'h2600, 16'h0001, 16'h0001);
      repeat (20) @(posedge mclk_in);
      chk(rep.size(), 0);
      chk(rx_ready_out, 1'b1);
      run(8'h03, 8'h03, 16'h2600, 16'h0001, {8'h02, 8'h12, 8'h34});
      print_verdict;
   end
endmodule

bind smrr_server smrr_server_props props_i (.mclk_in(mclk_in),
   .arst_n_in(arst_n_in), .rx_ready_out(rx_ready_out),
   .tx_valid_out(tx_valid_out), .tx_data_out(tx_data_out),
   .tx_last_out(tx_last_out), .tx_ready_in(tx_ready_in),
   .output_contacts_in(output_contacts_in));
